// *** src/asq_params.svh ***
`ifndef ASQ_PARAMS_SVH
`define ASQ_PARAMS_SVH

// Serial frame shape
`define ASQ_CTRL_BITS   4'h8
`define ASQ_RES_BITS    5'h10
`define ASQ_CNT_W       4
`define ASQ_CNT_FIRST   4'h1
`define ASQ_SHIFT_SEED  7'h01
`define ASQ_FRM_FIRST   5'h1
`define ASQ_CNT_CHAN    4'h3
`define ASQ_CNT_ACQ     4'h4
`define ASQ_CNT_SGL     4'h5
`define ASQ_CNT_LAST    4'h7
`define ASQ_BIT_MSB     4'hF
`define ASQ_SAR_SEED    16'h8000
`define ASQ_FRAME_CLKS  5'h18

// Channel select codes
`define ASQ_CH_A        3'h1
`define ASQ_CH_B        3'h5
`define ASQ_CH_C        3'h2
`define ASQ_CH_D        3'h6

// Multiplexer leg numbers; 4 is the common reference input
`define ASQ_LEG_0       3'h0
`define ASQ_LEG_1       3'h1
`define ASQ_LEG_2       3'h2
`define ASQ_LEG_3       3'h3
`define ASQ_LEG_COM     3'h4

// Power mode codes
`define ASQ_PM_AUTO     2'h0
`define ASQ_PM_INTCLK   2'h1
`define ASQ_PM_RSVD     2'h2
`define ASQ_PM_ON       2'h3

// Register map
`define ASQ_REG_CTRL    4'h0
`define ASQ_REG_STATUS  4'h4
`define ASQ_REG_RESULT  4'h8
`define ASQ_CTRL_RST    1'h1

`endif

// *** src/asq_pkg.sv ***
package asq_pkg;

    // Sequencer states, Gray coded along idle -> control -> convert
    typedef enum logic [1:0] {
        ASQ_IDLE = 2'h0,
        ASQ_CTRL = 2'h1,
        ASQ_CONV = 2'h3
    } asq_state_t;

    // Control byte, first bit received sits at the top
    typedef struct packed {
        logic       start;
        logic [2:0] channel_select;
        logic       spare;
        logic       single_diff_select;
        logic [1:0] power_mode_select;
    } asq_ctrl_t;

    // Analog multiplexer setting
    typedef struct packed {
        logic       valid;
        logic [2:0] pos_leg;
        logic [2:0] neg_leg;
    } asq_mux_t;

endpackage

// *** src/asq_sequencer.sv ***
// What this block does
// - each exchange eight clocks, conversion 24 clocks
// - acquire after channel bits, hold at byte end
// - sixteen conversion clocks, one bit each
// - single-ended codes map inputs against common
// - differential codes map input pairs and polarity
// - mux bits come only through serial input
// - result is 16-bit unsigned straight code
// - ignore input until high start bit
// - decode power mode field three ways, reserved code same as auto
// - sample rising, shift falling, tristate when deselected
// - busy one clock, then result MSB first
`include "asq_params.svh"

module asq_sequencer
    import asq_pkg::*;
(
    input  wire logic        ref_clk,        // 20 MHz system clock
    input  wire logic        rstn,           // Async reset, active low
    input  wire logic        serial_clock,   // Serial clock pin
    input  wire logic        cs_n,           // Chip select pin, active low
    input  wire logic        din,            // Serial data in pin
    input  wire logic        comp_in,        // Comparator decision from analog
    output logic             dout_o,         // Serial data out
    output logic             dout_oe,        // Drive enable for data out
    output logic             busy_o,         // Busy output
    output logic             busy_oe,        // Drive enable for busy
    output asq_mux_t         mux_o,          // Multiplexer setting
    output logic [15:0]      dac_code_o,     // Trial code for the capacitor DAC
    output logic             sample_o,       // Input in acquisition
    output logic             hold_o,         // Input held, converting
    output logic             powered_o,      // Analog section powered
    output logic             int_clk_mode_o, // Internal clock mode selected
    output logic             result_valid_o, // Pulse, new result stored
    input  wire logic [3:0]  reg_addr,       // Register byte address
    input  wire logic [31:0] reg_wdata,      // Register write data
    input  wire logic        reg_wr,         // Write strobe
    input  wire logic        reg_rd,         // Read strobe
    output logic [31:0]      reg_rdata       // Read data, one cycle later
);

    // Multiplexer decode from channel code and mode bit
    function automatic asq_mux_t asq_mux(input logic [2:0] ch, input logic sgl);
        asq_mux_t m;
        m = '0;
        m.valid = 1'b1;
        case (ch)
            `ASQ_CH_A: begin
                m.pos_leg = `ASQ_LEG_0;
                m.neg_leg = sgl ? `ASQ_LEG_COM : `ASQ_LEG_1;
            end
            `ASQ_CH_B: begin
                m.pos_leg = `ASQ_LEG_1;
                m.neg_leg = sgl ? `ASQ_LEG_COM : `ASQ_LEG_0;
            end
            `ASQ_CH_C: begin
                m.pos_leg = `ASQ_LEG_2;
                m.neg_leg = sgl ? `ASQ_LEG_COM : `ASQ_LEG_3;
            end
            `ASQ_CH_D: begin
                m.pos_leg = `ASQ_LEG_3;
                m.neg_leg = sgl ? `ASQ_LEG_COM : `ASQ_LEG_2;
            end
            default: m = '0;
        endcase
        return m;
    endfunction

    logic [2:0]            sclk_sq;
    logic [1:0]            cs_sq;
    logic [1:0]            din_sq;
    logic [1:0]            comp_sq;
    logic                  rise;
    logic                  fall;
    logic                  cs_s;
    logic                  din_s;
    logic                  comp_s;
    asq_state_t            state_q;
    logic [`ASQ_CNT_W-1:0] cnt_q;
    logic [6:0]            shift_q;
    logic [2:0]            chan_q;
    asq_ctrl_t             ctrl_q;
    logic [15:0]           sar_q;
    logic [15:0]           sar_d;
    logic [15:0]           result_q;
    logic                  last_bit_q;
    logic                  out_pend_q;
    logic                  busy_pend_q;
    logic                  enable_q;
    logic [4:0]            frm_q;
    asq_mux_t              stat_mux;

    // Pin synchronisers; serial clock keeps a third stage for edges
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sclk_sq <= '0;
            cs_sq   <= 2'h3;
            din_sq  <= '0;
            comp_sq <= '0;
        end else begin
            sclk_sq <= {sclk_sq[1:0], serial_clock};
            cs_sq   <= {cs_sq[0], cs_n};
            din_sq  <= {din_sq[0], din};
            comp_sq <= {comp_sq[0], comp_in};
        end
    end

    // Serial edges and settled levels
    assign rise   = sclk_sq[1] & ~sclk_sq[2];
    assign fall   = ~sclk_sq[1] & sclk_sq[2];
    assign cs_s   = cs_sq[1];
    assign din_s  = din_sq[1];
    assign comp_s = comp_sq[1];

    // Next SAR code: keep or drop trial bit, set the next one
    always_comb begin
        sar_d = sar_q;
        sar_d[cnt_q] = comp_s;
        if (cnt_q != '0) begin
            sar_d[cnt_q - 1'b1] = 1'b1;
        end
    end

    // Main sequencer on rising serial edges
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_q  <= ASQ_IDLE;
            cnt_q    <= '0;
            shift_q  <= '0;
            chan_q   <= '0;
            ctrl_q   <= '0;
            sar_q    <= '0;
            result_q <= '0;
            mux_o    <= '0;
            sample_o <= 1'b0;
            hold_o   <= 1'b0;
            result_valid_o <= 1'b0;
        end else begin
            result_valid_o <= 1'b0;
            if (cs_s) begin
                state_q  <= ASQ_IDLE;
                sample_o <= 1'b0;
                hold_o   <= 1'b0;
            end else if (rise) begin
                case (state_q)
                    ASQ_IDLE: begin
                        if (din_s && enable_q) begin
                            state_q <= ASQ_CTRL;
                            shift_q <= `ASQ_SHIFT_SEED;
                            cnt_q   <= `ASQ_CNT_FIRST;
                        end
                    end
                    ASQ_CTRL: begin
                        shift_q <= {shift_q[5:0], din_s};
                        cnt_q   <= cnt_q + 1'b1;
                        if (cnt_q == `ASQ_CNT_CHAN) begin
                            chan_q <= {shift_q[1:0], din_s};
                        end
                        if (cnt_q == `ASQ_CNT_ACQ) begin
                            sample_o <= 1'b1;
                            mux_o    <= asq_mux(chan_q, ctrl_q.single_diff_select);
                        end
                        if (cnt_q == `ASQ_CNT_SGL) begin
                            mux_o <= asq_mux(chan_q, din_s);
                        end
                        if (cnt_q == `ASQ_CNT_LAST) begin
                            ctrl_q   <= {shift_q, din_s};
                            state_q  <= ASQ_CONV;
                            sample_o <= 1'b0;
                            hold_o   <= 1'b1;
                            cnt_q    <= `ASQ_BIT_MSB;
                            sar_q    <= `ASQ_SAR_SEED;
                        end
                    end
                    ASQ_CONV: begin
                        sar_q <= sar_d;
                        cnt_q <= cnt_q - 1'b1;
                        if (cnt_q == '0) begin
                            result_q       <= sar_d;
                            result_valid_o <= 1'b1;
                            hold_o         <= 1'b0;
                            state_q        <= ASQ_IDLE;
                        end
                    end
                    default: state_q <= ASQ_IDLE;
                endcase
            end
        end
    end

    // Busy and data out change on falling serial edges
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            busy_o      <= 1'b0;
            busy_pend_q <= 1'b0;
            dout_o      <= 1'b0;
            out_pend_q  <= 1'b0;
            last_bit_q  <= 1'b0;
        end else if (cs_s) begin
            busy_o      <= 1'b0;
            busy_pend_q <= 1'b0;
            dout_o      <= 1'b0;
            out_pend_q  <= 1'b0;
        end else if (rise) begin
            if (state_q == ASQ_CTRL && cnt_q == `ASQ_CNT_LAST) begin
                busy_pend_q <= 1'b1;
            end
            if (state_q == ASQ_CONV) begin
                last_bit_q <= comp_s;
                out_pend_q <= 1'b1;
            end
        end else if (fall) begin
            busy_o      <= busy_pend_q;
            busy_pend_q <= 1'b0;
            dout_o      <= out_pend_q & last_bit_q;
            out_pend_q  <= 1'b0;
        end
    end

    // Output enables follow chip select
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            dout_oe <= 1'b0;
            busy_oe <= 1'b0;
        end else begin
            dout_oe <= ~cs_s;
            busy_oe <= ~cs_s;
        end
    end

    // Power mode decode and trial code
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            powered_o      <= 1'b0;
            int_clk_mode_o <= 1'b0;
            dac_code_o     <= '0;
        end else begin
            powered_o <= (state_q != ASQ_IDLE) ||
                         (ctrl_q.power_mode_select == `ASQ_PM_ON);
            int_clk_mode_o <= ctrl_q.power_mode_select == `ASQ_PM_INTCLK;
            dac_code_o     <= sar_q;
        end
    end

    // Register writes: enable bit gates start detection
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            enable_q <= `ASQ_CTRL_RST;
        end else if (reg_wr && reg_addr == `ASQ_REG_CTRL) begin
            enable_q <= reg_wdata[0];
        end
    end

    // Multiplexer decode of the stored control byte, for status
    assign stat_mux = asq_mux(ctrl_q.channel_select, ctrl_q.single_diff_select);

    // Register reads, zero for unmapped addresses
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                `ASQ_REG_CTRL:   reg_rdata <= {31'h0, enable_q};
                `ASQ_REG_STATUS: reg_rdata <= {20'h0, stat_mux.valid, busy_o, state_q, ctrl_q};
                `ASQ_REG_RESULT: reg_rdata <= {16'h0, result_q};
                default:         reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    // Serial clocks counted since the start bit
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            frm_q <= '0;
        end else if (rise && state_q == ASQ_IDLE) begin
            frm_q <= `ASQ_FRM_FIRST;
        end else if (rise) begin
            frm_q <= frm_q + 1'b1;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    AST_FRAME_LEN: assert property (result_valid_o |-> frm_q == `ASQ_FRAME_CLKS)
        else $error("conversion did not take 24 serial clocks");
    AST_ACQ_START: assert property ($rose(sample_o) |-> $past(cnt_q) == `ASQ_CNT_ACQ)
        else $error("acquisition began at wrong bit");
    AST_HOLD: assert property ($rose(hold_o) |-> !sample_o && state_q == ASQ_CONV)
        else $error("hold without leaving acquisition");
    AST_SAR_LEN: assert property ($rose(hold_o) |-> ##[1:1000] result_valid_o)
        else $error("conversion did not finish");
    AST_MUX_SGL: assert property (state_q == ASQ_CONV && ctrl_q.single_diff_select
        && ctrl_q.channel_select == `ASQ_CH_B |-> mux_o.pos_leg == `ASQ_LEG_1
        && mux_o.neg_leg == `ASQ_LEG_COM)
        else $error("single-ended code mis-mapped");
    AST_MUX_DIF: assert property (state_q == ASQ_CONV && !ctrl_q.single_diff_select
        && ctrl_q.channel_select == `ASQ_CH_D |-> mux_o.pos_leg == `ASQ_LEG_3
        && mux_o.neg_leg == `ASQ_LEG_2)
        else $error("differential code mis-mapped");
    AST_BUSY_ONE: assert property (busy_o && fall && !cs_s |=> !busy_o)
        else $error("busy longer than one serial clock");
    AST_HIZ: assert property (cs_s |=> !dout_oe && !busy_oe)
        else $error("outputs driven while deselected");
    AST_START: assert property (state_q == ASQ_IDLE && rise && !din_s
        |=> state_q == ASQ_IDLE)
        else $error("left idle without start bit");
    AST_RETURN: assert property (result_valid_o |-> state_q == ASQ_IDLE)
        else $error("not idle after last decision");
    AST_PWR: assert property (state_q == ASQ_IDLE && $past(state_q) == ASQ_IDLE
        && ctrl_q.power_mode_select == `ASQ_PM_AUTO |=> !powered_o)
        else $error("powered between conversions in auto mode");

    COV_CONV: cover property (result_valid_o);
    COV_BUSY: cover property ($rose(busy_o));
    COV_BACK: cover property (result_valid_o ##[1:200] state_q == ASQ_CTRL);
    COV_DESEL: cover property (state_q == ASQ_CONV ##1 cs_s);

endmodule

// *** tb/adc_serial_control_sequencer_tb.sv ***
module adc_serial_control_sequencer_tb import asq_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ns;

    logic        ref_clk, rstn, reg_wr, reg_rd;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic        serial_clock, cs_n, din, comp_in;
    logic        dout_o, dout_oe, busy_o, busy_oe, sample_o, hold_o;
    logic        powered_o, int_clk_mode_o, result_valid_o;
    logic [15:0] dac_code_o;
    asq_mux_t    mux_o;
    int          n_fail = 0;
    int          total_checks = 0;
    int          n_valid = 0;

    asq_sequencer dut_u (.ref_clk(ref_clk), .rstn(rstn), .serial_clock(serial_clock),
        .cs_n(cs_n), .din(din), .comp_in(comp_in), .dout_o(dout_o), .dout_oe(dout_oe),
        .busy_o(busy_o), .busy_oe(busy_oe), .mux_o(mux_o), .dac_code_o(dac_code_o),
        .sample_o(sample_o), .hold_o(hold_o), .powered_o(powered_o),
        .int_clk_mode_o(int_clk_mode_o), .result_valid_o(result_valid_o),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata));

    asq_host_model host_u (.ref_clk(ref_clk), .dout(dout_o), .busy(busy_o),
        .serial_clock(serial_clock), .cs_n(cs_n), .din(din), .comp_in(comp_in));

    // 20 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // Count result pulses
    always @(posedge ref_clk) begin
        if (result_valid_o === 1'b1) n_valid <= n_valid + 1;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic reg_check(input logic [3:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
        check(reg_rdata, exp);
    endtask

    // One conversion in a 32-clock frame with mid-frame and after-frame checks
    task automatic conv(input logic [7:0] ctl, input logic [15:0] tgt, input asq_mux_t mx);
        int v;
        v = n_valid;
        fork
            host_u.frame(32, {ctl, 56'h0}, {8'h0, tgt, 40'h0});
            begin
                wait (host_u.clk_idx == 7);
                check({sample_o, hold_o}, 2'b10);
                wait (host_u.clk_idx == 10);
                check({sample_o, hold_o, powered_o}, 3'b011);
                check(mux_o, mx);
                check({dout_oe, busy_oe}, 2'b11);
                check(dac_code_o, {tgt[15], 1'b1, 14'h0});
            end
        join
        check(host_u.rx_data[54:39], tgt);
        check(host_u.rx_data[38:32], 7'h0);
        check(host_u.rx_busy[56:54], 3'b010);
        repeat (6) @(posedge ref_clk);
        check({dout_oe, busy_oe}, 2'b00);
        check(n_valid, v + 1);
        check({powered_o, int_clk_mode_o}, {ctl[1:0] == 2'h3, ctl[1:0] == 2'h1});
        reg_check(4'h8, {16'h0, tgt});
        reg_check(4'h4, {20'h0, 1'b1, 1'b0, 2'h0, ctl});
    endtask

    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Cut a hang short
    initial begin
        repeat (30000) @(posedge ref_clk);
        n_fail++;
        print_verdict();
    end

    // Main sequence
    initial begin
        logic [2:0] chans [4];
        int         v;
        chans = '{3'h1, 3'h5, 3'h2, 3'h6};
        rstn      <= 1'b0;
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b0;
        reg_addr  <= 4'h0;
        reg_wdata <= 32'h0;
        repeat (10) @(posedge ref_clk);
        rstn <= 1'b1;
        reg_check(4'h0, 32'h1);
        reg_write(4'hC, 32'hFFFF_FFFF);
        reg_check(4'hC, 32'h0);
        // Every channel code in both input modes, every power mode
        for (int i = 0; i < 8; i++) begin
            conv({1'b1, chans[i[1:0]], 1'b0, i[2], i[1:0]}, 16'hA5C3 ^ 16'(16'h1111 * i),
                 {1'b1, 1'b0, i[1:0], i[2] ? 3'h4 : {1'b0, i[1:0] ^ 2'h1}});
        end
        // Start bit while disabled, then a frame of zeros while enabled
        v = n_valid;
        for (int e = 0; e < 2; e++) begin
            reg_write(4'h0, 32'(e));
            host_u.frame(32, (e == 0) ? {8'h97, 56'h0} : 64'h0, 64'h0);
            check(host_u.rx_busy[63:32], 32'h0);
        end
        check(n_valid, v);
        // Next control byte overlaps the last result bit
        v = n_valid;
        host_u.frame(56, {8'h97, 16'h0, 8'hE7, 32'h0}, {8'h0, 16'h8001, 8'h0, 16'h7FFE, 16'h0});
        check(host_u.rx_data[54:39], 16'h8001);
        check(host_u.rx_data[30:15], 16'h7FFE);
        check(host_u.rx_busy[32:30], 3'b010);
        check(n_valid, v + 2);
        print_verdict();
    end
endmodule

// *** tb/asq_host_model.sv ***
module asq_host_model (
    input  wire logic ref_clk,      // Timing base for the serial clock
    input  wire logic dout,         // Serial data from the device
    input  wire logic busy,         // Busy from the device
    output logic      serial_clock, // Serial clock, still between frames
    output logic      cs_n,         // Chip select, active low
    output logic      din,          // Serial data to the device
    output logic      comp_in       // Comparator decision per clock
);
    timeunit 1ns;
    timeprecision 1ns;

    int          clk_idx; // Rising edges given so far in this frame
    logic [63:0] rx_data; // Data out seen at rising edge c, in bit 64-c
    logic [63:0] rx_busy; // Busy seen at rising edge c, in bit 64-c

    // Lines idle at time zero
    initial begin
        serial_clock = 1'b0;
        cs_n         = 1'b1;
        din          = 1'b0;
        comp_in      = 1'b0;
        clk_idx      = 0;
    end

    // Half a serial period, 300 ns
    task automatic half();
        repeat (6) @(posedge ref_clk);
    endtask

    // One frame of n clocks; clock c sends tx and cmp bit 64-c
    task automatic frame(input int n, input logic [63:0] tx, input logic [63:0] cmp);
        rx_data = '0;
        rx_busy = '0;
        @(posedge ref_clk);
        cs_n <= 1'b0;
        for (int c = 1; c <= n; c++) begin
            din     <= tx[64-c];
            comp_in <= cmp[64-c];
            half();
            serial_clock <= 1'b1;
            rx_data[64-c] = dout;
            rx_busy[64-c] = busy;
            clk_idx = c;
            half();
            serial_clock <= 1'b0;
        end
        half();
        cs_n    <= 1'b1;
        din     <= ~din; // Released line inverts its last level
        clk_idx = 0;
    endtask
endmodule
